// ---- hdl/sadc_defs.svh ----
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
// result width and code limits
`define SADC_RES_W 12
`define SADC_CODE_MAX 12'hFFF
`define SADC_CODE_MID 12'h800
// configuration bit count after the start bit
`define SADC_CFG_BITS 3'h3
// shift periods of each output format
`define SADC_PERIODS_MSB 5'h11
`define SADC_PERIODS_REP 5'h1C
// avalon register offsets (byte addresses)
`define SADC_OFF_INPUT_A 4'h0
`define SADC_OFF_INPUT_B 4'h4
`define SADC_OFF_STATUS 4'h8
`define SADC_OFF_RESULT 4'hC
// status field positions
`define SADC_ST_SHUTDOWN 0
`define SADC_ST_BUSY 1
`define SADC_ST_SGL 2
`define SADC_ST_POL 3
`define SADC_ST_MSB_ONLY_FORMAT 4
`define SADC_ST_DONE 5
// reset values
`define SADC_INPUT_RST 12'h000
`endif

// ---- hdl/sadc_pkg.sv ----
package sadc_pkg;
	// serial sequencer states
	typedef enum logic [2:0] {
		SADC_IDLE,
		SADC_CFG,
		SADC_SAMPLE,
		SADC_CONV,
		SADC_REPEAT,
		SADC_HOLD
	} sadc_state_e;
	// result code type
	typedef logic [11:0] sadc_code_t;
endpackage

// ---- hdl/sadc_serial_ctrl.sv ----
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sadc_defs.svh"
// Behaviour
// - leading zeros dropped until first one
// - conversion needs select low plus start bit
// - three config bits follow start bit
// - mode bit zero differential, one single
// - polarity zero input_a positive, else input_b
// - single-ended uses ground as negative input
// - msb-only format: twelve bits, 17 periods
// - repeat format: msb then lsb, 28 periods
// - lsb not repeated in second half
// - each resolved bit drives output immediately
// - bit set when dac at or below input
// - output undriven while select high
// - reselect discards state, awaits start bit
// - shutdown whenever select is high
// - unsigned 12-bit code, midscale top bit
// - differential inputs sampled at one instant
module sadc_serial_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins from the host
	input wire logic select_n,
	input wire logic shift_clk,
	input wire logic data_in,
	// serial data out, three-state (oe low drives)
	output logic data_out_o,
	output logic data_out_oe_n,
	// power state
	output logic shutdown,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import sadc_pkg::*;

	// whole module state
	typedef struct packed {
		sadc_state_e st;
		logic sclk_d;
		logic [2:0] cfg_cnt;
		logic sgl;
		logic pol;
		logic msb_only_format;
		logic [3:0] bit_idx;
		sadc_code_t sar;
		sadc_code_t held_pos;
		sadc_code_t held_neg;
		logic [4:0] period;
		logic dout;
		logic drive;
		logic done;
		sadc_code_t result;
		sadc_code_t input_a;
		sadc_code_t input_b;
		logic ack;
		logic [31:0] rdata;
	} sadc_state_s;

	sadc_state_s s_reg;
	sadc_state_s s_next;

	// synchronised pins: select_n, shift clock, data in
	logic [2:0] pins_sync;
	logic sel_n_s;
	logic sclk_s;
	logic din_s;

	sadc_sync #(.W(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in({select_n, shift_clk, data_in}),
		.sync_out(pins_sync)
	);

	assign sel_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign din_s = pins_sync[0];

	// merge new byte lanes into a 12-bit input register
	function automatic sadc_code_t merge_code(input sadc_code_t old, input logic [31:0] wd,
		input logic [3:0] be);
		sadc_code_t m;
		m = old;
		if (be[0]) begin
			m[7:0] = wd[7:0];
		end
		if (be[1]) begin
			m[11:8] = wd[11:8];
		end
		return m;
	endfunction

	// edge strobes of the shift clock
	logic rise;
	logic fall;
	assign rise = sclk_s & ~s_reg.sclk_d;
	assign fall = ~sclk_s & s_reg.sclk_d;

	// analog model: positive and negative input chosen by the mux bits
	sadc_code_t mux_pos;
	sadc_code_t mux_neg;
	sadc_code_t diff;
	sadc_code_t trial;
	always_comb begin
		// positive input picked by polarity
		mux_pos = s_reg.pol ? s_reg.input_b : s_reg.input_a;
		if (s_reg.sgl) begin
			mux_neg = 12'h000;
		end else begin
			mux_neg = s_reg.pol ? s_reg.input_a : s_reg.input_b;
		end
	end

	// held difference, clamped at zero; trial dac level of current bit
	assign diff = (s_reg.held_pos > s_reg.held_neg) ? sadc_code_t'(s_reg.held_pos - s_reg.held_neg) : 12'h000;
	assign trial = s_reg.sar | sadc_code_t'(12'h001 << s_reg.bit_idx);

	// next-state logic
	always_comb begin
		s_next = s_reg;
		s_next.sclk_d = sclk_s;
		s_next.ack = 1'b0;

		// shutdown and reset of conversion while deselected
		if (sel_n_s) begin
			s_next.st = SADC_IDLE;
			s_next.drive = 1'b0;
			s_next.sar = 12'h000;
			s_next.period = 5'h00;
		end else begin
			// period counter counts shift-clock rises while selected, from the start bit on
			if (rise && s_reg.st != SADC_IDLE) begin
				s_next.period = s_reg.period + 5'h01;
			end
			case (s_reg.st)
				SADC_IDLE: begin
					// wait for first one, zeros dropped
					if (rise && din_s) begin
						s_next.st = SADC_CFG;
						s_next.cfg_cnt = 3'h0;
						s_next.period = 5'h01;
						s_next.done = 1'b0;
					end
				end
				SADC_CFG: begin
					// capture mode, polarity, format in order
					if (rise) begin
						case (s_reg.cfg_cnt)
							3'h0: s_next.sgl = din_s;
							3'h1: s_next.pol = din_s;
							default: s_next.msb_only_format = din_s;
						endcase
						s_next.cfg_cnt = s_reg.cfg_cnt + 3'h1;
						if (s_reg.cfg_cnt == `SADC_CFG_BITS - 3'h1) begin
							s_next.st = SADC_SAMPLE;
						end
					end
				end
				SADC_SAMPLE: begin
					// both inputs held at the same cycle, then null bit out
					if (fall) begin
						s_next.held_pos = mux_pos;
						s_next.held_neg = mux_neg;
						s_next.sar = 12'h000;
						s_next.bit_idx = 4'hB;
						s_next.drive = 1'b1;
						s_next.dout = 1'b0;
						s_next.st = SADC_CONV;
					end
				end
				SADC_CONV: begin
					// one bit per falling edge, msb first
					if (fall) begin
						if (trial <= diff) begin
							s_next.sar = trial;
							s_next.dout = 1'b1;
						end else begin
							s_next.dout = 1'b0;
						end
						if (s_reg.bit_idx == 4'h0) begin
							s_next.result = (trial <= diff) ? trial : s_reg.sar;
							s_next.done = 1'b1;
							s_next.st = s_reg.msb_only_format ? SADC_HOLD : SADC_REPEAT;
							s_next.bit_idx = 4'h1;
						end else begin
							s_next.bit_idx = s_reg.bit_idx - 4'h1;
						end
					end
				end
				SADC_REPEAT: begin
					// resend bit 1 upward to msb
					if (fall) begin
						s_next.dout = s_reg.result[s_reg.bit_idx];
						if (s_reg.bit_idx == 4'hB) begin
							s_next.st = SADC_HOLD;
						end else begin
							s_next.bit_idx = s_reg.bit_idx + 4'h1;
						end
					end
				end
				SADC_HOLD: begin
					// frame over; output low until host deselects
					if (fall) begin
						s_next.dout = 1'b0;
					end
				end
				default: s_next.st = SADC_IDLE;
			endcase
		end

		// avalon write lands at the edge where waitrequest is seen low
		if (avs_write && s_reg.ack) begin
			if (avs_address == `SADC_OFF_INPUT_A) begin
				s_next.input_a = merge_code(s_reg.input_a, avs_writedata, avs_byteenable);
			end else if (avs_address == `SADC_OFF_INPUT_B) begin
				s_next.input_b = merge_code(s_reg.input_b, avs_writedata, avs_byteenable);
			end
		end

		// avalon slave: one wait cycle, then answer
		if ((avs_read || avs_write) && !s_reg.ack) begin
			s_next.ack = 1'b1;
			s_next.rdata = 32'h0000_0000;
			if (avs_address == `SADC_OFF_INPUT_A) begin
				s_next.rdata = {20'h00000, s_reg.input_a};
			end else if (avs_address == `SADC_OFF_INPUT_B) begin
				s_next.rdata = {20'h00000, s_reg.input_b};
			end else if (avs_address == `SADC_OFF_STATUS) begin
				s_next.rdata[`SADC_ST_SHUTDOWN] = sel_n_s;
				s_next.rdata[`SADC_ST_BUSY] = (s_reg.st != SADC_IDLE);
				s_next.rdata[`SADC_ST_SGL] = s_reg.sgl;
				s_next.rdata[`SADC_ST_POL] = s_reg.pol;
				s_next.rdata[`SADC_ST_MSB_ONLY_FORMAT] = s_reg.msb_only_format;
				s_next.rdata[`SADC_ST_DONE] = s_reg.done;
			end else if (avs_address == `SADC_OFF_RESULT) begin
				s_next.rdata = {20'h00000, s_reg.result};
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// pin and bus outputs
	assign data_out_o = s_reg.dout;
	assign data_out_oe_n = ~(s_reg.drive & ~sel_n_s);
	assign shutdown = sel_n_s;
	assign avs_readdata = s_reg.rdata;
	assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.ack;
endmodule

// ---- hdl/sadc_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for a group of pin levels
module sadc_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// first and second stages; the first is read only by the second
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// plain two-stage capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// ---- sim/sadc_host_model.sv ----
`timescale 1ns/1ps
// host end of the serial link
module sadc_host_model (
	// clock
	input wire logic clk,
	// pins
	output logic select_n,
	output logic shift_clk,
	output logic data_in,
	input wire logic data_out_o,
	input wire logic data_out_oe_n
);
	// a released line shows the inverse of its last value
	wire pin = data_out_oe_n ? ~data_out_o : data_out_o;
	initial begin
		select_n = 1'b1;
		shift_clk = 1'b0;
		data_in = 1'b0;
	end
	// two zeros, start, config, then reply bits; n+2 rises in all
	task automatic run(input logic [2:0] cfg, input int n, output logic [23:0] got);
		logic [5:0] tx;
		tx = {3'h1, cfg};
		got = 24'h0;
		@(posedge clk) select_n <= 1'b0;
		for (int i = 0; i < n + 2; i++) begin
			repeat (20) @(posedge clk);
			shift_clk <= 1'b0;
			data_in <= (i < 6) ? tx[5 - i] : 1'b0;
			repeat (20) @(posedge clk);
			shift_clk <= 1'b1;
			if (i > 5) got = {got[22:0], pin};
		end
		repeat (20) @(posedge clk);
		shift_clk <= 1'b0;
		repeat (20) @(posedge clk);
		select_n <= 1'b1;
		repeat (20) @(posedge clk);
	endtask
endmodule

// ---- sim/sadc_serial_ctrl_bench.sv ----
`timescale 1ns/1ps
// self-checking bench
module sadc_serial_ctrl_bench;
	import sadc_pkg::*;
	// config {single, polarity, msb only}, inputs, code
	typedef struct {logic [2:0] cfg; sadc_code_t a; sadc_code_t b; sadc_code_t code;} sadc_row_s;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: %h %h", $time, g, e); end end
	logic clk = 1'b0;
	logic rst = 1'b1;
	wire select_n, shift_clk, data_in, data_out_o, data_out_oe_n, shutdown, avs_waitrequest;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] q;
	logic [23:0] got;
	logic [23:0] want;
	sadc_row_s rows [8] = '{'{3'h4, 12'h800, 12'h123, 12'h800}, '{3'h7, 12'hFFF, 12'h5A3, 12'h5A3},
		'{3'h1, 12'hFFF, 12'h001, 12'hFFE}, '{3'h2, 12'h100, 12'hFFF, 12'hEFF},
		'{3'h0, 12'h100, 12'h200, 12'h000}, '{3'h5, 12'hFFF, 12'h000, 12'hFFF},
		'{3'h3, 12'h123, 12'h456, 12'h333}, '{3'h6, 12'h000, 12'h001, 12'h001}};
	always #2 clk = ~clk;
	sadc_serial_ctrl i_sadc_serial_ctrl (.clk(clk), .rst(rst), .select_n(select_n), .shift_clk(shift_clk),
		.data_in(data_in), .data_out_o(data_out_o), .data_out_oe_n(data_out_oe_n), .shutdown(shutdown),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	sadc_host_model i_sadc_host_model (.clk(clk), .select_n(select_n), .shift_clk(shift_clk),
		.data_in(data_in), .data_out_o(data_out_o), .data_out_oe_n(data_out_oe_n));
	// one bus access, held until waitrequest is low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// load inputs, run a frame, check reply, status and result
	task automatic conv(input sadc_row_s r);
		bus(1'b1, 4'h0, {20'h0, r.a});
		bus(1'b1, 4'h4, {20'h0, r.b});
		i_sadc_host_model.run(r.cfg, r.cfg[0] ? 17 : 28, got);
		want = r.cfg[0] ? {12'h0, r.code} : {1'b0, r.code, 11'h0};
		for (int k = 0; k < 11 && !r.cfg[0]; k++) want[10 - k] = r.code[k + 1];
		`CHK(got, want)
		bus(1'b0, 4'h8, 32'h0);
		`CHK({q[4:2], q[0]}, {r.cfg[0], r.cfg[1], r.cfg[2], 1'b1})
		bus(1'b0, 4'hC, 32'h0);
		`CHK(q[11:0], r.code)
	endtask
	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		foreach (rows[i]) conv(rows[i]);
		// abandon a frame mid reply, then a clean frame
		i_sadc_host_model.run(3'h1, 10, got);
		conv(rows[2]);
		// reset in mid-run clears the inputs
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		`CHK(q, 32'h0)
		summarize();
	end
endmodule

// ---- sim/sadc_serial_ctrl_monitor.sv ----
`timescale 1ns/1ps
// pin and bus watcher
module sadc_serial_ctrl_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins
	input wire logic select_n,
	input wire logic shift_clk,
	input wire logic data_out_o,
	input wire logic data_out_oe_n,
	input wire logic shutdown,
	// bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	pin_release_a: assert property (select_n [*4] |-> data_out_oe_n) else $error("dout driven");
	drive_awake_a: assert property (!data_out_oe_n |-> !shutdown) else $error("drive asleep");
	auto_sleep_a: assert property (select_n [*4] |-> shutdown) else $error("no shutdown");
	wake_up_a: assert property (!select_n [*4] |-> !shutdown) else $error("still asleep");
	out_steady_a: assert property (shift_clk [*8] |-> $stable(data_out_o)) else $error("dout moved");
	wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("early answer");
	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("late answer");
	hole_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("hole read");
endmodule
bind sadc_serial_ctrl sadc_serial_ctrl_monitor i_sadc_serial_ctrl_monitor (.clk(clk), .rst(rst),
	.select_n(select_n), .shift_clk(shift_clk), .data_out_o(data_out_o), .data_out_oe_n(data_out_oe_n),
	.shutdown(shutdown), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
